// >>> spbf_core.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Operation
// R1 - empty flag high only while transmit buffer empty
// R2 - data register write clears empty flag
// R3 - handler must refill or mask empty interrupt
// R4 - select low in host mode forces client
// R5 - takeover flag only when select line enabled
// R6 - writing one clears takeover flag
// R7 - overrun when both receive stages full, third arrives
// R8 - no transmit data: overrun waits next transfer
// R9 - data read or write-one clears overrun
// R10 - host write starts transfer, client write stages
// R11 - written byte shifts out on serial line
// R12 - normal mode: write shift, read receive register
// R13 - buffered mode write loads transmit buffer
// R14 - buffered read returns buffer, then advances stage
// R15 - buffered mode: two receive, one transmit stage
// R16 - receive flag tracks unread data, write-one clears
// R17 - transmit-complete when shifted out, buffer empty; the code sets it in buffered mode only
// R18 - interrupt when enabled flag is set
module spbf_core (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // register port
  input  wire spbf_pkg::spbf_bus_req_t i_bus,
  output logic [7:0]                  o_rdata,
  output logic                        o_irq,
  // serial pins
  input  wire spbf_pkg::spbf_pin_in_t i_pins,
  output logic                        o_sck,
  output logic                        o_sck_oe,
  output logic                        o_mosi,
  output logic                        o_mosi_oe,
  output logic                        o_miso,
  output logic                        o_miso_oe
);
  import spbf_pkg::*;

  spbf_state_t s_reg;
  spbf_state_t s_next;
  logic        done;
  logic        start;
  logic        take;
  logic [7:0]  rx_byte;
  logic [7:0]  clr_bits;

  always_comb begin
    s_next  = s_reg;
    done    = 1'b0;
    start   = 1'b0;
    take    = 1'b0;
    rx_byte = s_reg.shift;
    // the empty flag follows the buffer level, so a write of one never clears it
    clr_bits = i_bus.wdata & FLAG_MASK;
    clr_bits[FLG_DRE] = 1'b0; // [R1]
    // pins pass two flops before any logic reads them
    s_next.sync1    = i_pins;
    s_next.sync2    = s_reg.sync1;
    s_next.sck_prev = s_reg.sync2.sck;
    s_next.ss_prev  = s_reg.sync2.ss_n;
    s_next.rdata    = 8'h00;

    // register reads
    if (i_bus.rd) begin
      case (i_bus.addr)
        OFS_CTRL:   s_next.rdata = s_reg.ctrl;
        OFS_INTEN:  s_next.rdata = s_reg.inten;
        OFS_STATUS: s_next.rdata = s_reg.flags;
        OFS_DATA: begin
          s_next.flags[FLG_OVF] = 1'b0; // [R9]
          if (s_reg.ctrl[CTRL_BUFFERED_MODE_ENABLE]) begin
            s_next.rdata       = s_reg.rxbuf; // [R14]
            s_next.rxbuf       = s_reg.rxdata; // [R14]
            s_next.rxbuf_full  = s_reg.rxdata_full;
            s_next.rxdata_full = 1'b0;
            s_next.flags[FLG_RXC] = s_reg.rxdata_full; // [R16]
          end else begin
            s_next.rdata = s_reg.rxdata; // [R12]
            s_next.rxdata_full = 1'b0;
            s_next.flags[FLG_RXC] = 1'b0;
          end
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    // buffered mode: move staged byte into the idle shifter
    if (s_reg.ctrl[CTRL_BUFFERED_MODE_ENABLE] && !s_reg.busy && !s_reg.pend && s_reg.txbuf_full) begin
      s_next.shift      = s_reg.txbuf; // [R15]
      s_next.txbuf_full = 1'b0;
      s_next.pend       = 1'b1;
      s_next.flags[FLG_DRE] = 1'b1; // [R1]
    end

    // register writes; moving first lets a write in the same cycle refill the buffer
    if (i_bus.wr) begin
      case (i_bus.addr)
        OFS_CTRL:  s_next.ctrl  = i_bus.wdata & CTRL_MASK;
        OFS_INTEN: s_next.inten = i_bus.wdata & FLAG_MASK;
        OFS_STATUS, OFS_CLEAR:
          s_next.flags = s_next.flags & ~clr_bits; // [R6] [R9] [R16] [R17]
        OFS_DATA: begin
          s_next.flags[FLG_DRE] = 1'b0; // [R2]
          if (s_reg.ctrl[CTRL_BUFFERED_MODE_ENABLE]) begin
            s_next.txbuf      = i_bus.wdata; // [R13]
            s_next.txbuf_full = 1'b1;
          end else if (!s_reg.busy && !s_reg.pend) begin
            // a write during a transfer is dropped in normal mode
            s_next.shift = i_bus.wdata; // [R12]
            s_next.pend  = 1'b1; // [R10]
          end
        end
        default: ;
      endcase
    end

    // select taken over by another host
    if (s_reg.ctrl[CTRL_EN] && s_reg.ctrl[CTRL_HOST] && !s_reg.ctrl[CTRL_SSD]
        && !s_reg.sync2.ss_n) begin
      take = 1'b1;
      s_next.ctrl[CTRL_HOST] = 1'b0; // [R4]
      s_next.flags[FLG_SST]  = 1'b1; // [R4] [R5]
      s_next.busy  = 1'b0;
      s_next.sck_q = 1'b0;
    end else if (s_reg.ctrl[CTRL_EN] && s_reg.ctrl[CTRL_HOST]) begin
      if (!s_reg.busy && s_reg.pend) begin
        start        = 1'b1; // [R10]
        s_next.busy  = 1'b1;
        s_next.pend  = 1'b0;
        s_next.bitcnt = 4'h0;
        s_next.div   = 8'h00;
        s_next.sck_q = 1'b0;
        s_next.sdo_q = s_reg.shift[7]; // [R11]
      end else if (s_reg.busy) begin
        if (s_reg.div == SCK_HALF_CYC - 8'h01) begin
          s_next.div = 8'h00;
          if (!s_reg.sck_q) begin
            s_next.sck_q  = 1'b1;
            s_next.shift  = {s_reg.shift[6:0], s_reg.sync2.miso};
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else begin
            s_next.sck_q = 1'b0;
            if (s_reg.bitcnt == BYTE_BITS) begin
              done        = 1'b1;
              s_next.busy = 1'b0;
            end else begin
              s_next.sdo_q = s_reg.shift[7]; // [R11]
            end
          end
        end else begin
          s_next.div = s_reg.div + 8'h01;
        end
      end
    end else if (s_reg.ctrl[CTRL_EN]) begin
      // client: the other party clocks; a staged byte waits for select
      if (s_reg.ss_prev && !s_reg.sync2.ss_n) begin
        start         = 1'b1; // [R10]
        s_next.busy   = 1'b1;
        s_next.pend   = 1'b0;
        s_next.bitcnt = 4'h0;
        s_next.sdo_q  = s_next.shift[7]; // [R11]
      end else if (s_reg.busy && s_reg.sync2.ss_n) begin
        s_next.busy = 1'b0;
      end else if (s_reg.busy) begin
        if (s_reg.sync2.sck && !s_reg.sck_prev) begin
          rx_byte       = {s_reg.shift[6:0], s_reg.sync2.mosi};
          s_next.shift  = rx_byte;
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
          if (s_reg.bitcnt == BYTE_BITS - 4'h1) begin
            done        = 1'b1;
            s_next.busy = 1'b0;
          end
        end else if (!s_reg.sync2.sck && s_reg.sck_prev) begin
          s_next.sdo_q = s_reg.shift[7]; // [R11]
        end
      end
    end else begin
      s_next.busy  = 1'b0;
      s_next.sck_q = 1'b0;
    end

    if (done) begin
      rx_byte = s_next.shift;
      if (!s_reg.ctrl[CTRL_BUFFERED_MODE_ENABLE]) begin
        s_next.rxdata      = rx_byte; // [R12]
        s_next.rxdata_full = 1'b1;
        s_next.flags[FLG_RXC] = 1'b1;
        s_next.flags[FLG_DRE] = 1'b1; // [R1]
      end else begin
        if (!s_next.rxbuf_full) begin
          s_next.rxbuf      = rx_byte; // [R15]
          s_next.rxbuf_full = 1'b1;
          s_next.flags[FLG_RXC] = 1'b1; // [R16]
        end else if (!s_next.rxdata_full) begin
          s_next.rxdata      = rx_byte; // [R15]
          s_next.rxdata_full = 1'b1;
        end else if (s_next.txbuf_full || s_next.pend) begin
          s_next.flags[FLG_OVF] = 1'b1; // [R7]
        end else begin
          s_next.ovf_pend = 1'b1; // [R8]
        end
        if (!s_next.txbuf_full) begin
          s_next.flags[FLG_TXC] = 1'b1; // [R17]
        end
      end
    end
    if (start && s_reg.ovf_pend) begin
      s_next.flags[FLG_OVF] = 1'b1; // [R8]
      s_next.ovf_pend = 1'b0;
    end

    s_next.sck_oe  = s_next.ctrl[CTRL_EN] && s_next.ctrl[CTRL_HOST];
    s_next.mosi_oe = s_next.ctrl[CTRL_EN] && s_next.ctrl[CTRL_HOST];
    s_next.miso_oe = s_next.ctrl[CTRL_EN] && !s_next.ctrl[CTRL_HOST] && !s_reg.sync2.ss_n;
    s_next.irq     = |(s_next.flags & s_next.inten); // [R18]
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_reg       <= '0;
      s_reg.ctrl  <= CTRL_RST;
      s_reg.inten <= INTEN_RST;
      s_reg.flags <= FLAGS_RST;
      s_reg.shift <= DATA_RST;
      s_reg.sync1.ss_n <= 1'b1;
      s_reg.sync2.ss_n <= 1'b1;
      s_reg.ss_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata   = s_reg.rdata;
  assign o_irq     = s_reg.irq;
  assign o_sck     = s_reg.sck_q;
  assign o_sck_oe  = s_reg.sck_oe;
  assign o_mosi    = s_reg.sdo_q;
  assign o_mosi_oe = s_reg.mosi_oe;
  assign o_miso    = s_reg.sdo_q;
  assign o_miso_oe = s_reg.miso_oe;

  // assertion helpers
  logic wr_data;
  logic rd_data;
  logic buffered_mode_enable;
  assign wr_data = i_bus.wr && (i_bus.addr == OFS_DATA);
  assign rd_data = i_bus.rd && (i_bus.addr == OFS_DATA);
  assign buffered_mode_enable   = s_reg.ctrl[CTRL_BUFFERED_MODE_ENABLE];

  sequence host_write_s;
    wr_data && !buffered_mode_enable && s_reg.ctrl[CTRL_EN] && s_reg.ctrl[CTRL_HOST] && !s_reg.busy
      && !s_reg.pend && s_reg.sync2.ss_n && s_reg.sync1.ss_n && i_pins.ss_n;
  endsequence
  sequence shift_runs_s;
    s_reg.busy [*2];
  endsequence

  dre_full_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R1]
    (buffered_mode_enable && s_reg.txbuf_full) |-> !s_reg.flags[FLG_DRE])
    else $error("empty flag high with byte buffered");
  dre_clear_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
    (wr_data && !done) |=> !s_reg.flags[FLG_DRE])
    else $error("data write did not clear empty flag");
  take_over_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
    (s_reg.ctrl[CTRL_EN] && s_reg.ctrl[CTRL_HOST] && !s_reg.ctrl[CTRL_SSD]
     && !s_reg.sync2.ss_n) |=> (!s_reg.ctrl[CTRL_HOST] && s_reg.flags[FLG_SST]))
    else $error("select takeover not handled");
  ssd_block_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
    $rose(s_reg.flags[FLG_SST]) |-> !$past(s_reg.ctrl[CTRL_SSD]))
    else $error("takeover flag set with select disabled");
  sst_w1c_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R6]
    (i_bus.wr && i_bus.addr == OFS_STATUS && i_bus.wdata[FLG_SST] && !take)
      |=> !s_reg.flags[FLG_SST])
    else $error("takeover flag not cleared by write of one");
  ovf_cause_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R7]
    $rose(s_reg.flags[FLG_OVF])
      |-> $past((s_reg.rxbuf_full && s_reg.rxdata_full) || s_reg.ovf_pend))
    else $error("overrun without both stages full");
  ovf_read_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R9]
    (rd_data && !done && !start) |=> !s_reg.flags[FLG_OVF])
    else $error("data read did not clear overrun");
  host_start_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R10]
    host_write_s |-> ##2 shift_runs_s)
    else $error("host write did not start a transfer");
  buf_load_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
    (wr_data && buffered_mode_enable) |=> (s_reg.txbuf == $past(i_bus.wdata) && s_reg.txbuf_full))
    else $error("buffered write missed transmit buffer");
  irq_level_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R18]
    (|(s_reg.flags & s_reg.inten)) |-> o_irq)
    else $error("interrupt low with enabled flag set");
  rd_norm_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
    (rd_data && !buffered_mode_enable) |=> (o_rdata == $past(s_reg.rxdata)))
    else $error("normal data read missed receive register");
  rd_buf_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R14]
    (rd_data && buffered_mode_enable && !done)
      |=> (o_rdata == $past(s_reg.rxbuf) && s_reg.rxbuf == $past(s_reg.rxdata)))
    else $error("buffered data read did not advance stages");
  rxc_empty_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R16]
    (rd_data && buffered_mode_enable && !s_reg.rxdata_full && !done) |=> !s_reg.flags[FLG_RXC])
    else $error("receive flag stayed set with buffer empty");
  txc_set_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R17]
    $rose(s_reg.flags[FLG_TXC]) |-> ($past(done) && !s_reg.txbuf_full))
    else $error("transmit-complete set with byte still buffered");
  mosi_first_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
    (start && s_reg.ctrl[CTRL_HOST]) |=> (o_mosi == $past(s_reg.shift[7])))
    else $error("first bit not on serial output");

endmodule : spbf_core

// >>> spbf_pkg.sv
package spbf_pkg;

  // register offsets on the internal port
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INTEN  = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_CLEAR  = 8'h05;

  // control bit positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_HOST  = 1;
  localparam int CTRL_SSD   = 2;
  localparam int CTRL_BUFFERED_MODE_ENABLE = 7;
  localparam logic [7:0] CTRL_MASK = 8'h87;

  // status flag positions, shared by enable and clear registers
  localparam int FLG_RXC = 7;
  localparam int FLG_TXC = 6;
  localparam int FLG_DRE = 5;
  localparam int FLG_SST = 4;
  localparam int FLG_OVF = 0;
  localparam logic [7:0] FLAG_MASK = 8'hf1;

  // values after reset
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] INTEN_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h20;
  localparam logic [7:0] DATA_RST  = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCK_HALF_NS   = 100;
  localparam logic [7:0] SCK_HALF_CYC =
    8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spbf_bus_req_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spbf_pin_in_t;

  typedef struct packed {
    logic [7:0]   ctrl;
    logic [7:0]   inten;
    logic [7:0]   flags;
    logic [7:0]   shift;
    logic [3:0]   bitcnt;
    logic         busy;
    logic         pend;
    logic [7:0]   txbuf;
    logic         txbuf_full;
    logic [7:0]   rxdata;
    logic         rxdata_full;
    logic [7:0]   rxbuf;
    logic         rxbuf_full;
    logic         ovf_pend;
    logic [7:0]   div;
    logic         sck_q;
    logic         sdo_q;
    logic         sck_oe;
    logic         mosi_oe;
    logic         miso_oe;
    logic [7:0]   rdata;
    logic         irq;
    spbf_pin_in_t sync1;
    spbf_pin_in_t sync2;
    logic         sck_prev;
    logic         ss_prev;
  } spbf_state_t;

endpackage : spbf_pkg

// >>> spbf_spi_client.sv
`timescale 1ns/1ps
module spbf_spi_client (
  // link pins
  input  wire logic i_sel,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output logic      o_miso
);
  logic [7:0] sh  = 8'hc3;
  logic [7:0] cur = 8'hc3;
  logic [7:0] rx  = 8'h00;
  logic [7:0] sent_q[$];
  logic [7:0] got_q[$];
  int         n   = 0;
  // deselected: show the inverse so a stale bit never passes
  assign o_miso = i_sel ? sh[7] : ~sh[7];
  // mode 0, msb first: sample on rising, shift on falling
  always @(posedge i_sck) if (i_sel) begin
    rx = {rx[6:0], i_mosi};
    n++;
  end
  always @(negedge i_sck) if (i_sel) begin
    if (n == 8) begin
      sent_q.push_back(cur);
      got_q.push_back(rx);
      cur = {cur[6:0], cur[7] ^ cur[5]} + 8'h11;
      sh = cur;
      n = 0;
    end else if (n != 0) begin
      // a stray falling edge between bytes must not shift
      sh = sh << 1;
    end
  end
endmodule : spbf_spi_client

// >>> test_spi_buffered_data_flags.sv
`timescale 1ns/1ps
module test_spi_buffered_data_flags;
  import spbf_pkg::*;
  logic          i_clk   = 1'b0;
  logic          i_reset = 1'b1;
  spbf_bus_req_t bus     = '0;
  spbf_pin_in_t  pins;
  logic [7:0]    rdata, d, e;
  logic [7:0]    b[4];
  logic          irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, p_miso;
  logic          h_sck = 1'b0, h_mosi = 1'b0, ss_n = 1'b1, p_sel = 1'b1;
  logic [15:0]   lf = 16'd20533;
  int            err_count = 0, num_checks = 0;
  logic [7:0]    ra[6] = '{OFS_CTRL, OFS_INTEN, OFS_STATUS, OFS_DATA, 8'h01, OFS_CLEAR};
  logic [7:0]    re[6] = '{CTRL_RST, INTEN_RST, FLAGS_RST, DATA_RST, 8'h00, 8'h00};
  // sck, mosi and miso each take whichever party enables it; ss_n always comes from the bench
  assign pins = '{sck_oe ? sck : h_sck, mosi_oe ? mosi : h_mosi, miso_oe ? miso : p_miso, ss_n};
  always #12.5 i_clk = ~i_clk;
  spbf_core dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata), .o_irq(irq),
    .i_pins(pins), .o_sck(sck), .o_sck_oe(sck_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
    .o_miso(miso), .o_miso_oe(miso_oe));
  spbf_spi_client p_u (.i_sel(p_sel), .i_sck(pins.sck), .i_mosi(pins.mosi), .o_miso(p_miso));
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1 v = rdata;
    @(posedge i_clk);
  endtask : rd
  // bounded poll; running out counts as a mismatch
  task automatic wait_flag(input int f);
    for (int k = 0; k < 400; k++) begin
      rd(OFS_STATUS, d);
      if (d[f] === 1'b1) return;
    end
    err_count++;
    end_sim();
  endtask : wait_flag
  // bench as host, 200 ns link clock, phase unrelated to i_clk
  task automatic host_xfer(input logic [7:0] mo, output logic [7:0] mi);
    #7 ss_n = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      h_mosi = mo[i];
      #100 h_sck = 1'b1;
      mi[i] = pins.miso;
      #100 h_sck = 1'b0;
    end
    #200 ss_n = 1'b1;
    @(posedge i_clk);
  endtask : host_xfer
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk(d, re[i]);
    end
    $display("reset values done");
    wr(OFS_CTRL, 8'h03);
    e = rnd();
    wr(OFS_DATA, e);
    wait_flag(FLG_RXC);
    rd(OFS_DATA, d);
    chk(d, p_u.sent_q.pop_front());
    chk(p_u.got_q.pop_front(), e);
    $display("normal host done");
    wr(OFS_CTRL, 8'h83);
    foreach (b[i]) b[i] = rnd();
    wr(OFS_DATA, b[0]);
    wr(OFS_DATA, b[1]);
    rd(OFS_STATUS, d);
    chk(d & 8'h20, 8'h00);
    wait_flag(FLG_TXC);
    chk(d & 8'h60, 8'h60);
    wr(OFS_STATUS, 8'h40);
    rd(OFS_STATUS, d);
    chk(d & 8'h40, 8'h00);
    wr(OFS_DATA, b[2]);
    wait_flag(FLG_TXC);
    chk(d & 8'h81, 8'h80);
    wr(OFS_CLEAR, 8'h40);
    wr(OFS_DATA, b[3]);
    @(posedge i_clk);
    rd(OFS_STATUS, d);
    chk(d & 8'h01, 8'h01);
    rd(OFS_DATA, d);
    chk(d, p_u.sent_q.pop_front());
    rd(OFS_STATUS, d);
    chk(d & 8'h01, 8'h00);
    rd(OFS_DATA, d);
    chk(d, p_u.sent_q.pop_front());
    e = p_u.sent_q.pop_front();
    wait_flag(FLG_TXC);
    rd(OFS_DATA, d);
    chk(d, p_u.sent_q.pop_front());
    rd(OFS_STATUS, d);
    chk(d & 8'h81, 8'h00);
    foreach (b[i]) chk(p_u.got_q.pop_front(), b[i]);
    $display("buffered done");
    wr(OFS_INTEN, 8'h20);
    #1 chk({7'h00, irq}, 8'h01);
    wr(OFS_INTEN, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    $display("interrupt done");
    wr(OFS_CTRL, 8'h03);
    wr(OFS_INTEN, 8'h10);
    ss_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd(OFS_STATUS, d);
    chk(d & 8'h10, 8'h10);
    chk({6'h00, irq, sck_oe}, 8'h02);
    wr(OFS_CLEAR, 8'h00);
    rd(OFS_STATUS, d);
    chk(d & 8'h10, 8'h10);
    wr(OFS_CLEAR, 8'h10);
    rd(OFS_STATUS, d);
    chk(d & 8'h10, 8'h00);
    ss_n <= 1'b1;
    wr(OFS_CTRL, 8'h07);
    ss_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd(OFS_STATUS, d);
    chk({3'h0, d[4], 3'h0, sck_oe}, 8'h01);
    ss_n <= 1'b1;
    $display("takeover done");
    wr(OFS_CTRL, 8'h01);
    p_sel <= 1'b0;
    e = rnd();
    wr(OFS_DATA, e);
    chk({7'h00, sck_oe}, 8'h00);
    b[0] = rnd();
    host_xfer(b[0], d);
    chk(d, e);
    repeat (8) @(posedge i_clk);
    rd(OFS_DATA, d);
    chk(d, b[0]);
    $display("client done");
    end_sim();
  end
endmodule : test_spi_buffered_data_flags
